// >>> rtl/acsr_top.sv
// soft reset sequencer and card configuration registers, APB slave
// assumes the disk controller logic shares core_clk and drives the diag
// and interrupt inputs; there is no DMA or diagnostic handshake pin here
//
// Overview of operation
// - No passed-diagnostic or drive-active signal is driven or used.
// - Disabled interrupts leave the interrupt output inactive, not floating.
// - No DMA mode; only programmed register access exists.
// - Soft reset restarts the controller but keeps configuration registers.
// - Single drive: busy within 400 ns of reset bit set, then init.
// - Single drive: diag result posted, busy drops once commands accepted.
// - Twin setup: every drive raises busy within 400 ns of reset set.
// - Drive 1 drops busy within 50 ms after reset bit cleared.
// - Drive 1 posts real diag result, else pass code 01h.
// - Before busy drops, ready flag reflects ability to run commands.
// - Drive 0 holds busy 100 ms in twin setup, 0 ms alone.
// - Twin drive 0 reports its result as if drive 1 passed.
// - Busy never drops before ready flag and diag result are posted; card reset (option bit 7) drops it at once.
// - Unsupported configuration bits ignore writes and read zero.
// - Option register holds mode index, level/pulse irq, card reset.
// - Function status register optional; status change needs pin register.
// - Power-down bit puts drive in lowest power until written zero.
// - Interrupt request bit is pending interrupt gated by enable.
// - Memory-only mode keeps interrupt bit but no hardware interrupt.
// - Byte I/O hint is stored only, never changes data width.
// - Pin replacement register present only when ready must be reported.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module acsr_top
    import acsr_pkg::*;
#(
    parameter int unsigned HOLD0_CYC = DRV0_HOLD_CYC,
    parameter int unsigned DRV1_CYC  = DRV1_LIMIT_CYC,
    parameter bit          HAS_FCSR  = 1'b1,
    parameter bit          HAS_PINREP = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        diagDone,
    input  wire logic [7:0]  diagResult,
    input  wire logic        driveReady,
    input  wire logic        intPending,
    output logic             ctlResetOut,
    output logic             busyOut,
    output logic             readyOut,
    output logic             irqReqN,
    output logic             powerDownOut,
    output logic             hostByteIoHint,
    output logic             driveSelOut
);
    localparam int unsigned DECIDE_CYC = DRV1_CYC - DECIDE_MARGIN;

    // refuse windows the counter or the decision margin cannot hold
    if (HOLD0_CYC >= (1 << TIMER_W) || DRV1_CYC >= (1 << TIMER_W) ||
        DRV1_CYC <= DECIDE_MARGIN + POST_GAP_CYC || HOLD0_CYC < 1) begin : g_bad
        $error("acsr_top: timer parameters out of range");
    end

    acsr_regs_s r;
    acsr_regs_s n;
    logic       tmrStart;
    logic       tmrExp;
    logic       setupPh;
    logic       wrEn;

    acsr_timer #(
        .W       (TIMER_W)
    ) u_timer (
        .core_clk(core_clk),
        .rstn    (rstn),
        .start   (tmrStart),
        .loadVal (r.drvSel ? TIMER_W'(DECIDE_CYC) : TIMER_W'(HOLD0_CYC)),
        .expired (tmrExp)
    );

    ////////////////////////////////////////////////////////////////////////
    // register file, interrupt path and reset sequencer in one next-state
    always_comb begin
        logic [31:0] rd;
        logic        hit;
        logic        act;
        logic        memOnly;
        logic        drive1;
        rd       = 32'h0000_0000;
        hit      = 1'b1;
        act      = 1'b0;
        n        = r;
        tmrStart = 1'b0;
        memOnly  = (r.opt[5:0] == 6'h00);
        drive1   = r.twin && r.drvSel;
        // zero-wait APB: data latched at setup, pready in the access cycle
        setupPh  = psel && !penable;
        wrEn     = psel && penable && r.pready && pwrite && !r.pslverr;
        unique case ({paddr[7:2], 2'b00})
            OFS_DEVCTL: begin
                rd[DEVCTL_SRST] = r.srst;
                rd[DEVCTL_NIEN] = r.nIen;
            end
            OFS_STATUS: begin
                rd[STATUS_BSY]  = r.bsy;
                rd[STATUS_DRDY] = r.drdy;
            end
            OFS_ERROR:  rd[7:0] = r.err;
            OFS_OPTION: rd[7:0] = r.opt;
            OFS_FCSR: begin
                // absent register reads a stable zero
                rd[FCSR_INTR]   = HAS_FCSR && r.intrBit;
                rd[FCSR_PWRDN]  = HAS_FCSR && r.pwrDn;
                rd[FCSR_BYTEIO] = HAS_FCSR && r.byteIo;
            end
            OFS_SOCKET: rd[SOCKET_DRV] = r.drvSel;
            // ready seen through the I/O path only if fitted
            OFS_PINREP: rd[PINREP_READY] = HAS_PINREP && !r.bsy;
            OFS_CTRL:   rd[CTRL_TWIN] = r.twin;
            default:    hit = 1'b0;
        endcase
        n.pready = setupPh;
        if (setupPh) begin
            n.prdata  = rd;
            n.pslverr = !hit;
        end

        // other bits of each register drop on write
        if (wrEn) begin
            unique case ({paddr[7:2], 2'b00})
                OFS_DEVCTL: begin
                    n.srst = pwdata[DEVCTL_SRST];
                    n.nIen = pwdata[DEVCTL_NIEN];
                end
                OFS_OPTION: n.opt = pwdata[7:0];
                OFS_FCSR: begin
                    if (HAS_FCSR) begin
                        n.pwrDn  = pwdata[FCSR_PWRDN];
                        // kept as a hint only
                        n.byteIo = pwdata[FCSR_BYTEIO];
                    end
                end
                OFS_SOCKET: n.drvSel = pwdata[SOCKET_DRV];
                OFS_CTRL:   n.twin = pwdata[CTRL_TWIN];
                default: ;
            endcase
        end

        // interrupt bit mirrors memory-only mode too
        n.intrBit = intPending && !r.nIen;
        // no pin drive in memory-only or disabled mode
        act       = n.intrBit && !memOnly;
        n.irqN    = r.opt[OPT_LEVEL] ? !act : !(act && !r.actPrev);
        n.actPrev = act;

        // sequencer; status flags only, no handshake pins
        unique case (r.st)
            S_IDLE: begin
                if (r.srst) begin
                    // busy one edge after the set
                    n.st     = S_RST;
                    n.bsy    = 1'b1;
                    n.drdy   = 1'b0;
                    n.ctlRst = 1'b1;
                end else begin
                    // controller leaves reset once a card reset is lifted
                    n.ctlRst = 1'b0;
                end
            end
            S_RST: begin
                if (!r.srst) begin
                    // windows start at the clearing write
                    n.st     = S_INIT;
                    n.ctlRst = 1'b0;
                    tmrStart = 1'b1;
                end
            end
            S_INIT: begin
                if (r.srst) begin
                    n.st     = S_RST;
                    n.ctlRst = 1'b1;
                end else if (drive1) begin
                    // decide early enough to meet the limit
                    if (tmrExp || (diagDone && driveReady)) begin
                        n.st   = S_POST;
                        n.err  = diagDone ? diagResult : DIAG_PASS;
                        n.drdy = driveReady;
                    end
                end else if (diagDone && (!r.twin || tmrExp)) begin
                    // hold only when twin
                    n.st   = S_POST;
                    // drive 1 taken as passed
                    n.err  = diagResult;
                    n.drdy = driveReady;
                end
            end
            S_POST: begin
                // results stand at least a cycle first
                n.st  = S_REL;
                n.bsy = 1'b0;
            end
            S_REL: n.st = S_IDLE;
            default: n.st = S_IDLE;
        endcase

        // card soft reset clears all but itself; the ATA reset does not
        if (r.opt[OPT_SRESET]) begin
            n.st     = S_IDLE;
            n.bsy    = 1'b0;
            n.drdy   = 1'b0;
            n.err    = 8'h00;
            n.srst   = 1'b0;
            n.nIen   = 1'b0;
            n.opt    = {n.opt[OPT_SRESET], 7'h00};
            n.byteIo = 1'b0;
            n.pwrDn  = 1'b0;
            n.drvSel = 1'b0;
            n.twin   = 1'b0;
            n.irqN   = 1'b1;
            n.ctlRst = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // single state register
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    // every output straight from the state register; DMA absent
    assign prdata         = r.prdata;
    assign pready         = r.pready;
    assign pslverr        = r.pslverr;
    assign ctlResetOut    = r.ctlRst;
    assign busyOut        = r.bsy;
    assign readyOut       = r.drdy;
    assign irqReqN        = r.irqN;
    assign powerDownOut   = r.pwrDn;
    assign hostByteIoHint = r.byteIo;
    assign driveSelOut    = r.drvSel;

    ////////////////////////////////////////////////////////////////////////
    // checks; elapsed counts cycles since the reset bit was cleared
    localparam int BsyMax = BUSY_LIMIT_CYC;
    logic [TIMER_W-1:0] elapsed;

    always_ff @(posedge core_clk) begin
        if (!rstn || r.st == S_RST) begin
            elapsed <= '0;
        end else if (r.st == S_INIT || r.st == S_POST) begin
            elapsed <= elapsed + TIMER_W'(1);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_busyRise;
        $rose(r.srst) |-> ##[1:BsyMax] r.bsy;
    endproperty
    a_busyRise: assert property (p_busyRise)
        else $error("busy late after reset set");

    property p_postFirst;
        $fell(r.bsy) && !$past(r.opt[OPT_SRESET]) |-> $past(r.st == S_POST);
    endproperty
    a_postFirst: assert property (p_postFirst)
        else $error("busy dropped without posting");

    property p_drv1Limit;
        (r.twin && r.drvSel && r.bsy && r.st != S_RST) |-> elapsed <= DRV1_CYC;
    endproperty
    a_drv1Limit: assert property (p_drv1Limit)
        else $error("drive 1 busy past limit");

    property p_drv0Hold;
        $fell(r.bsy) && r.twin && !r.drvSel && !$past(r.opt[OPT_SRESET])
            |-> elapsed >= HOLD0_CYC;
    endproperty
    a_drv0Hold: assert property (p_drv0Hold)
        else $error("drive 0 released too early");

    property p_passCode;
        (r.st == S_INIT && n.st == S_POST && r.twin && r.drvSel && !diagDone)
            |=> r.err == DIAG_PASS;
    endproperty
    a_passCode: assert property (p_passCode)
        else $error("drive 1 pass code missing");

    property p_drdyPost;
        (r.st == S_POST) |-> r.drdy == $past(driveReady) ##1 !r.bsy;
    endproperty
    a_drdyPost: assert property (p_drdyPost)
        else $error("ready flag not posted before release");

    property p_intrBit;
        !$past(r.opt[OPT_SRESET]) |-> r.intrBit == $past(intPending && !r.nIen);
    endproperty
    a_intrBit: assert property (p_intrBit)
        else $error("interrupt bit mismatch");

    property p_irqIdle;
        (r.nIen || r.opt[5:0] == 6'h00) |=> r.irqN;
    endproperty
    a_irqIdle: assert property (p_irqIdle)
        else $error("interrupt driven while disabled");

    property p_cfgKeep;
        (r.st == S_RST && !wrEn && !r.opt[OPT_SRESET])
            |=> $stable(r.opt) && $stable(r.drvSel) && $stable(r.byteIo);
    endproperty
    a_cfgKeep: assert property (p_cfgKeep)
        else $error("configuration changed by soft reset");

    c_drv1: cover property ($fell(r.bsy) && r.twin && r.drvSel);
    c_drv0: cover property ($fell(r.bsy) && r.twin && !r.drvSel);
    c_single: cover property ($fell(r.bsy) && !r.twin);
    c_pass: cover property (r.st == S_POST && r.err == DIAG_PASS && r.drvSel);
endmodule

// >>> rtl/acsr_pkg.sv
// constants, register map and state types for the soft reset sequencer
// assumes a 20 MHz core clock and a 32-bit APB register bus
package acsr_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned BUSY_LIMIT_NS   = 400;  // busy_assert_limit
    localparam int unsigned DRV0_HOLD_MS    = 100;  // first_drive_release_delay
    localparam int unsigned DRV1_LIMIT_MS   = 50;   // second_drive_completion_limit
    localparam int unsigned POST_GAP_NS     = 0;    // post_to_release_gap
    localparam int unsigned NS_PER_MS       = 1000000;
    localparam int unsigned BUSY_LIMIT_CYC  = BUSY_LIMIT_NS / CLK_PERIOD_NS;
    localparam int unsigned DRV0_HOLD_CYC   =
        (DRV0_HOLD_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DRV1_LIMIT_CYC  =
        (DRV1_LIMIT_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int unsigned POST_GAP_CYC    =
        (POST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (POST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DECIDE_MARGIN   = 4;
    localparam int unsigned TIMER_W         = 21;

    // register byte offsets
    localparam logic [7:0] OFS_DEVCTL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ERROR  = 8'h08;
    localparam logic [7:0] OFS_OPTION = 8'h0c;
    localparam logic [7:0] OFS_FCSR   = 8'h10;
    localparam logic [7:0] OFS_SOCKET = 8'h14;
    localparam logic [7:0] OFS_PINREP = 8'h18;
    localparam logic [7:0] OFS_CTRL   = 8'h1c;

    // field positions
    localparam int DEVCTL_NIEN  = 1;
    localparam int DEVCTL_SRST  = 2;
    localparam int STATUS_DRDY  = 6;
    localparam int STATUS_BSY   = 7;
    localparam int OPT_SRESET   = 7;
    localparam int OPT_LEVEL    = 6;
    localparam int FCSR_INTR    = 1;
    localparam int FCSR_PWRDN   = 2;
    localparam int FCSR_BYTEIO  = 5;
    localparam int SOCKET_DRV   = 4;
    localparam int PINREP_READY = 1;
    localparam int CTRL_TWIN    = 0;

    localparam logic [7:0] DIAG_PASS = 8'h01;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RST  = 5'b00010,
        S_INIT = 5'b00100,
        S_POST = 5'b01000,
        S_REL  = 5'b10000
    } acsr_state_e;

    typedef struct packed {
        acsr_state_e st;
        logic [7:0]  err;
        logic        bsy;
        logic        drdy;
        logic        srst;
        logic        nIen;
        logic [7:0]  opt;
        logic        byteIo;
        logic        pwrDn;
        logic        drvSel;
        logic        twin;
        logic        intrBit;
        logic        irqN;
        logic        actPrev;
        logic        ctlRst;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } acsr_regs_s;

    localparam acsr_regs_s REGS_RST = '{
        st: S_IDLE, err: 8'h00, bsy: 1'b0, drdy: 1'b0, srst: 1'b0,
        nIen: 1'b0, opt: 8'h00, byteIo: 1'b0, pwrDn: 1'b0, drvSel: 1'b0,
        twin: 1'b0, intrBit: 1'b0, irqN: 1'b1, actPrev: 1'b0,
        ctlRst: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};

endpackage

// >>> rtl/acsr_timer.sv
// down-counting interval timer used for the release windows
// assumes start is a one-cycle pulse from the same clock domain
`timescale 1ns/1ps
module acsr_timer #(
    parameter int unsigned W = 21
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic         start,
    input  wire logic [W-1:0] loadVal,
    output logic              expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         run;
        logic         exp;
    } acsr_tmr_s;

    acsr_tmr_s r;
    acsr_tmr_s n;

    // expired rises loadVal edges after the start edge
    always_comb begin
        n = r;
        if (start) begin
            n.cnt = loadVal;
            n.run = 1'b1;
            n.exp = 1'b0;
        end else if (r.run) begin
            if (r.cnt > W'(1)) begin
                n.cnt = r.cnt - W'(1);
            end else begin
                n.run = 1'b0;
                n.exp = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign expired = r.exp;
endmodule

// >>> test/acsr_ctl_model.sv
// behavioural disk controller facing the sequencer's diag inputs
// assumes ctlRst is the sequencer's controller reset level on core_clk
`timescale 1ns/1ps
module acsr_ctl_model (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       ctlRst,
    input  wire logic [7:0] dlyCyc,
    input  wire logic [7:0] resVal,
    input  wire logic       rdyVal,
    input  wire logic       intReq,
    output logic            diagDone,
    output logic [7:0]      diagResult,
    output logic            driveReady,
    output logic            intPending
);
    logic [7:0] cnt_q;
    ////////////////////////////////////////////////////////////////////////
    // diagnostics restart on each controller reset; the result lines carry
    // the inverse value until done so a stale read cannot pass by chance
    always_ff @(posedge core_clk) begin
        if (!rstn || ctlRst) begin
            cnt_q      <= 8'h00;
            diagDone   <= 1'b0;
            driveReady <= 1'b0;
            diagResult <= ~resVal;
            intPending <= 1'b0;
        end else begin
            intPending <= intReq;
            if (cnt_q < dlyCyc) begin
                cnt_q      <= cnt_q + 8'h01;
                diagResult <= ~resVal;
            end else begin
                diagDone   <= 1'b1;
                diagResult <= resVal;
                driveReady <= rdyVal;
            end
        end
    end
endmodule

// >>> test/acsr_top_bench.sv
// self-checking bench for the soft reset sequencer over APB
// assumes the controller model stands on the diag side of the block
`timescale 1ns/1ps
module acsr_top_bench;
    import acsr_pkg::*;
    localparam int H0 = 40;
    localparam int D1 = 30;
    logic        core_clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        diagDone;
    logic [7:0]  diagResult;
    logic        driveReady;
    logic        intPending;
    logic        ctlResetOut;
    logic        busyOut;
    logic        readyOut;
    logic        irqReqN;
    logic        powerDownOut;
    logic        hostByteIoHint;
    logic        driveSelOut;
    logic [7:0]  dlyCyc;
    logic [7:0]  resVal;
    logic        rdyVal;
    logic        intReq;
    logic [31:0] rdData;
    logic        rdErr;
    int          bad_count;
    int          n_checks;
    int          rel;

    acsr_top #(.HOLD0_CYC(H0), .DRV1_CYC(D1)) dut (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .diagDone(diagDone),
        .diagResult(diagResult), .driveReady(driveReady),
        .intPending(intPending), .ctlResetOut(ctlResetOut),
        .busyOut(busyOut), .readyOut(readyOut), .irqReqN(irqReqN),
        .powerDownOut(powerDownOut), .hostByteIoHint(hostByteIoHint),
        .driveSelOut(driveSelOut));

    acsr_ctl_model ctl (
        .core_clk(core_clk), .rstn(rstn), .ctlRst(ctlResetOut),
        .dlyCyc(dlyCyc), .resVal(resVal), .rdyVal(rdyVal),
        .intReq(intReq), .diagDone(diagDone), .diagResult(diagResult),
        .driveReady(driveReady), .intPending(intPending));

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one APB transfer; the request holds until pready is sampled high or 16 edges pass
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) bad_count++;
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdData);
    endtask

    // set then clear the reset bit; rel counts edges until busy falls
    task automatic sreset(output int r);
        int n;
        apb(1'b1, OFS_DEVCTL, 32'h0000_0004);
        n = 0;
        while (busyOut !== 1'b1 && n <= BUSY_LIMIT_CYC + 1) begin
            @(posedge core_clk);
            n++;
        end
        chk("bsy up", 1, n < BUSY_LIMIT_CYC + 2);
        chk("ctl reset", 1, ctlResetOut);
        apb(1'b1, OFS_DEVCTL, 32'h0000_0000);
        n = 0;
        while (busyOut !== 1'b0 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        r = n;
    endtask

    task automatic t_single;
        dlyCyc <= 8'h0a;
        resVal <= 8'h05;
        rdyVal <= 1'b1;
        apb(1'b1, OFS_SOCKET, 32'h0000_0010);
        apb(1'b1, OFS_OPTION, 32'h0000_0041);
        sreset(rel);
        chk("single release", 1, rel < 5000);
        chk("ready pin", 1, readyOut);
        rd(OFS_ERROR, 32'h0000_0005, "error");
        rd(OFS_STATUS, 32'h0000_0040, "status");
        rd(OFS_SOCKET, 32'h0000_0010, "socket");
        rd(OFS_OPTION, 32'h0000_0041, "option");
        chk("drive sel", 1, driveSelOut);
        $display("test single done");
    endtask

    task automatic t_twin0;
        dlyCyc <= 8'h04;
        resVal <= 8'h07;
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        apb(1'b1, OFS_SOCKET, 32'h0000_0000);
        sreset(rel);
        chk("drive0 hold", 1, rel >= H0 && rel < 5000);
        rd(OFS_ERROR, 32'h0000_0007, "error");
        rd(OFS_STATUS, 32'h0000_0040, "status");
        $display("test twin drive 0 done");
    endtask

    // slow diag forces the pass code, fast diag posts the real result
    task automatic t_twin1;
        apb(1'b1, OFS_SOCKET, 32'h0000_0010);
        for (int k = 0; k < 2; k++) begin
            dlyCyc <= (k == 0) ? 8'hc8 : 8'h03;
            resVal <= 8'h09;
            sreset(rel);
            chk("drive1 limit", 1, rel <= D1);
            rd(OFS_ERROR, k ? 32'h09 : 32'h01, "error");
            rd(OFS_STATUS, k ? 32'h40 : 32'h00, "status");
        end
        $display("test twin drive 1 done");
    endtask

    task automatic t_irq;
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        intReq <= 1'b1;
        apb(1'b1, OFS_DEVCTL, 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        rd(OFS_FCSR, 32'h0000_0002, "irq bit");
        chk("irq pin", 0, irqReqN);
        apb(1'b1, OFS_DEVCTL, 32'h0000_0002);
        repeat (3) @(posedge core_clk);
        rd(OFS_FCSR, 32'h0000_0000, "irq off");
        chk("irq pin off", 1, irqReqN);
        apb(1'b1, OFS_DEVCTL, 32'h0000_0000);
        apb(1'b1, OFS_OPTION, 32'h0000_0040);
        repeat (3) @(posedge core_clk);
        rd(OFS_FCSR, 32'h0000_0002, "mem irq bit");
        chk("mem irq pin", 1, irqReqN);
        // pulse mode: leaving memory-only makes one low cycle on the pin
        apb(1'b1, OFS_OPTION, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        chk("pulse low", 0, irqReqN);
        @(posedge core_clk);
        chk("pulse end", 1, irqReqN);
        intReq <= 1'b0;
        $display("test irq done");
    endtask

    task automatic t_cfg;
        // outputs settle at the write edge; look one edge later
        apb(1'b1, OFS_FCSR, 32'h0000_0024);
        @(posedge core_clk);
        chk("byte hint", 1, hostByteIoHint);
        chk("power down", 1, powerDownOut);
        apb(1'b1, OFS_FCSR, 32'h0000_0020);
        @(posedge core_clk);
        chk("power up", 0, powerDownOut);
        apb(1'b1, OFS_SOCKET, 32'hffff_ffff);
        rd(OFS_SOCKET, 32'h0000_0010, "socket bits");
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped err", 1, rdErr);
        chk("unmapped data", 0, rdData);
        // card reset acts one edge after the bit lands
        apb(1'b1, OFS_OPTION, 32'h0000_0080);
        repeat (2) @(posedge core_clk);
        chk("card reset", 1, ctlResetOut);
        rd(OFS_SOCKET, 32'h0000_0000, "socket clr");
        apb(1'b1, OFS_OPTION, 32'h0000_0000);
        rd(OFS_OPTION, 32'h0000_0000, "option clr");
        chk("card reset end", 0, ctlResetOut);
        $display("test config done");
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence; tests need well under 5000 cycles
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        dlyCyc = 8'h00;
        resVal = 8'h00;
        rdyVal = 1'b0;
        intReq = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        rd(OFS_STATUS, 32'h0000_0000, "status rst");
        chk("irq rst", 1, irqReqN);
        t_single();
        t_twin0();
        t_twin1();
        t_irq();
        t_cfg();
        test_done();
    end

    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        test_done();
    end
endmodule
